// ### common/pssc_pkg.sv
// pssc_pkg: states, timing counts and carrier structs of the power sequencer
// assumes a 100 MHz always-on standby clock
package pssc_pkg;
   localparam int CLK_MHZ = 100;
   localparam int HOLD_MS = 4000; // long-press threshold
   localparam int HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
   localparam int DEB_US = 10; // switch debounce window
   localparam int DEB_CYC = DEB_US * CLK_MHZ;
   localparam int BOOT_US = 100; // cold boot reset hold
   localparam int BOOT_CYC = BOOT_US * CLK_MHZ;

   // sleep-state request codes from software
   localparam logic [2:0] REQ_S0 = 3'h0;
   localparam logic [2:0] REQ_S1 = 3'h1;
   localparam logic [2:0] REQ_S2 = 3'h2;
   localparam logic [2:0] REQ_S3 = 3'h3;
   localparam logic [2:0] REQ_S4 = 3'h4;
   localparam logic [2:0] REQ_S5 = 3'h5;

   // gray along off -> boot -> on -> sleep
   typedef enum logic [2:0] {
      PSSC_OFF = 3'h0,
      PSSC_BOOT = 3'h1,
      PSSC_ON = 3'h3,
      PSSC_S1 = 3'h2,
      PSSC_S3 = 3'h6,
      PSSC_S4 = 3'h7
   } pssc_state_e;

   typedef struct packed {
      logic pmeEn; // wake on pme line
      logic pmeS5En; // pme/lan wake also from soft-off
      logic usbEn; // wake on usb activity
      logic rtcEn; // wake on rtc alarm
      logic lanEn; // wake on lan
      logic restoreOn; // after power loss, restore previous state
   } pssc_cfg_s;

   typedef struct packed {
      logic cpuPwr; // processor rail
      logic cpuStopGrant; // processor halted in stop-grant
      logic platPwr; // main platform rails
      logic memPwr; // memory self-refresh rail
      logic wakePwr; // device wake logic rail
      logic coldReset; // cold boot reset to platform
   } pssc_pwr_s;
endpackage

// ### hw/pssc_top.sv
// pssc_top: power switch and sleep state controller
// assumes clk is always-on standby, srst is power-good; pins are async
// How it works
//[R1] off plus short press: power on
//[R2] on plus short press: enter sleep
//[R3] on plus long hold: force soft-off
//[R4] sleeping plus short press: wake to on
//[R5] sleeping plus long hold: go soft-off
//[R6] supports S0 S1 S3 S4 S5; S2 rejected
//[R7] software initiates state transitions
//[R8] S1: cpu stop-grant, platform powered
//[R9] S3: memory kept, cpu off, wake only
//[R10] S4: cpu off, wake logic only
//[R11] leaving S5 always does cold boot
//[R12] pme wakes S1-S5 when enabled
//[R13] usb wakes only S1 and S3
//[R14] restore on/off after mains loss
//[R15] S5 pme/lan wake off after reset
//[R16] debounce switch, long hold fires while held
//[R17] short press on release; one long action
`timescale 1ns/1ps
`default_nettype none
module pssc_top
   import pssc_pkg::*;
#(
   parameter int HOLD_CYCLES = HOLD_CYC, // long-press count
   parameter int DEB_CYCLES = DEB_CYC, // debounce count
   parameter int BOOT_CYCLES = BOOT_CYC // cold boot count
) (
   input wire logic clk, // standby clock
   input wire logic srst, // sync reset, high
   input wire logic pwrBtnN, // front panel switch, low pressed
   input wire logic pmeN, // pci wake line, low active
   input wire logic usbWake, // usb resume activity
   input wire logic rtcAlarm, // rtc alarm
   input wire logic lanWake, // lan wake
   input wire logic acWasOn, // state held before mains loss
   input wire logic reqValid, // software request strobe
   input wire logic [2:0] reqState, // requested sleep state
   input wire pssc_pkg::pssc_cfg_s cfg, // wake options, from logic
   input wire logic cfgS5Write, // pulse: load cfg.pmeS5En
   output pssc_pkg::pssc_pwr_s pwr, // power controls
   output logic [2:0] curState, // current state code
   output logic reqReject // pulse: unsupported request while on and no button event, or request while asleep and no button event or wake
);
   import pssc_pkg::*;

   localparam int CW = $clog2(HOLD_CYCLES + 1);
   localparam int DW = $clog2(DEB_CYCLES + 1);

   // two-flop synchronisers for the pin inputs
   logic [4:0] syn1_r, syn2_r;
   always_ff @(posedge clk) begin
      syn1_r <= {~pwrBtnN, ~pmeN, usbWake, rtcAlarm, lanWake};
      syn2_r <= syn1_r;
   end
   logic btnRaw, pmeS, usbS, rtcS, lanS;
   assign {btnRaw, pmeS, usbS, rtcS, lanS} = syn2_r;

   // debounce and hold timing
   logic btn_r, btn_nxt, longDone_r, longDone_nxt;
   logic [DW-1:0] deb_r, deb_nxt;
   logic [CW-1:0] hold_r, hold_nxt;
   logic shortEv, longEv;
   always_comb begin
      btn_nxt = btn_r;
      deb_nxt = deb_r;
      hold_nxt = hold_r;
      longDone_nxt = longDone_r;
      shortEv = 1'b0;
      longEv = 1'b0;
      if (btnRaw == btn_r) begin
         deb_nxt = '0;
      end else if (deb_r == DW'(DEB_CYCLES - 1)) begin //R16
         deb_nxt = '0;
         btn_nxt = btnRaw;
      end else begin
         deb_nxt = deb_r + 1'b1;
      end
      if (btn_r) begin
         if (hold_r == CW'(HOLD_CYCLES - 1) && !longDone_r) begin
            longEv = 1'b1; //R16
            longDone_nxt = 1'b1; //R17
         end else if (hold_r != CW'(HOLD_CYCLES - 1)) begin
            hold_nxt = hold_r + 1'b1;
         end
      end
      if (btn_r && !btn_nxt) begin
         shortEv = !longDone_r && !longEv; //R17
         hold_nxt = '0;
         longDone_nxt = 1'b0;
      end
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         btn_r <= 1'b0;
         deb_r <= '0;
         hold_r <= '0;
         longDone_r <= 1'b0;
      end else begin
         btn_r <= btn_nxt;
         deb_r <= deb_nxt;
         hold_r <= hold_nxt;
         longDone_r <= longDone_nxt;
      end
   end

   // s5 wake enable cleared by reset, set only by configuration write
   logic s5En_r, s5En_nxt;
   always_comb begin
      s5En_nxt = s5En_r;
      if (cfgS5Write) begin
         s5En_nxt = cfg.pmeS5En; //R15
      end
   end

   // state machine
   pssc_state_e st_r, st_nxt;
   logic [15:0] boot_r, boot_nxt;
   logic strap_r, strap_nxt, rej_nxt, rej_r;
   logic slpWake, offWake;
   pssc_pwr_s pwr_r, pwr_nxt;
   always_comb begin
      // usb only counts from the shallow states
      slpWake = (cfg.pmeEn && pmeS) || (cfg.rtcEn && rtcS)
         || (cfg.lanEn && lanS) //R12
         || (cfg.usbEn && usbS && (st_r == PSSC_S1 || st_r == PSSC_S3)); //R13
      offWake = (s5En_r && (pmeS && cfg.pmeEn || lanS && cfg.lanEn))
         || (cfg.rtcEn && rtcS); //R15
      st_nxt = st_r;
      // counter restarts on every entry to boot, wake from s4 included
      boot_nxt = '0;
      strap_nxt = 1'b0;
      rej_nxt = 1'b0;
      case (st_r)
         PSSC_OFF: begin
            if (strap_r && cfg.restoreOn && acWasOn) begin
               st_nxt = PSSC_BOOT; //R14
            end else if (shortEv || offWake) begin
               st_nxt = PSSC_BOOT; //R1 R11 R12
            end
            boot_nxt = '0;
         end
         PSSC_BOOT: begin
            if (longEv) begin
               st_nxt = PSSC_OFF;
            end else if (boot_r == 16'(BOOT_CYCLES - 1)) begin
               st_nxt = PSSC_ON; //R11
            end else begin
               boot_nxt = boot_r + 16'h1;
            end
         end
         PSSC_ON: begin
            if (longEv) begin
               st_nxt = PSSC_OFF; //R3
            end else if (shortEv) begin
               st_nxt = PSSC_S1; //R2
            end else if (reqValid) begin //R7
               case (reqState)
                  REQ_S1: st_nxt = PSSC_S1;
                  REQ_S3: st_nxt = PSSC_S3;
                  REQ_S4: st_nxt = PSSC_S4;
                  REQ_S5: st_nxt = PSSC_OFF;
                  REQ_S0: st_nxt = PSSC_ON;
                  default: rej_nxt = 1'b1; //R6
               endcase
            end
         end
         PSSC_S1, PSSC_S3, PSSC_S4: begin
            if (longEv) begin
               st_nxt = PSSC_OFF; //R5
            end else if (shortEv || slpWake) begin
               // s4 lost cpu context, so it boots like cold
               st_nxt = (st_r == PSSC_S4) ? PSSC_BOOT : PSSC_ON; //R4
            end else if (reqValid) begin
               rej_nxt = 1'b1;
            end
         end
         default: st_nxt = PSSC_OFF;
      endcase
      pwr_nxt = '0;
      pwr_nxt.wakePwr = 1'b1; //R9 R10
      case (st_nxt)
         PSSC_BOOT: begin
            pwr_nxt.cpuPwr = 1'b1;
            pwr_nxt.platPwr = 1'b1;
            pwr_nxt.memPwr = 1'b1;
            pwr_nxt.coldReset = 1'b1; //R11
         end
         PSSC_ON: begin
            pwr_nxt.cpuPwr = 1'b1;
            pwr_nxt.platPwr = 1'b1;
            pwr_nxt.memPwr = 1'b1;
         end
         PSSC_S1: begin
            pwr_nxt.cpuPwr = 1'b1;
            pwr_nxt.cpuStopGrant = 1'b1; //R8
            pwr_nxt.platPwr = 1'b1;
            pwr_nxt.memPwr = 1'b1;
         end
         PSSC_S3: pwr_nxt.memPwr = 1'b1; //R9
         default: pwr_nxt.memPwr = 1'b0; //R10
      endcase
   end
   always_ff @(posedge clk) begin
      if (srst) begin
         st_r <= PSSC_OFF;
         boot_r <= '0;
         strap_r <= 1'b1;
         rej_r <= 1'b0;
         s5En_r <= 1'b0;
         pwr_r <= '0;
      end else begin
         st_r <= st_nxt;
         boot_r <= boot_nxt;
         strap_r <= strap_nxt;
         rej_r <= rej_nxt;
         s5En_r <= s5En_nxt;
         pwr_r <= pwr_nxt;
      end
   end

   logic [2:0] code_r;
   always_ff @(posedge clk) begin
      if (srst) begin
         code_r <= REQ_S5;
      end else begin
         case (st_nxt)
            PSSC_ON, PSSC_BOOT: code_r <= REQ_S0;
            PSSC_S1: code_r <= REQ_S1;
            PSSC_S3: code_r <= REQ_S3;
            PSSC_S4: code_r <= REQ_S4;
            default: code_r <= REQ_S5;
         endcase
      end
   end
   assign pwr = pwr_r;
   assign curState = code_r;
   assign reqReject = rej_r;

   AST_LONG_OFF: assert property (@(posedge clk) disable iff (srst) //R3
      longEv && st_r == PSSC_ON |=> st_r == PSSC_OFF)
      else $error("long hold did not power off");
   AST_SHORT_ON: assert property (@(posedge clk) disable iff (srst) //R1
      shortEv && st_r == PSSC_OFF |=> st_r == PSSC_BOOT)
      else $error("short press did not start boot");
   AST_SLEEP: assert property (@(posedge clk) disable iff (srst) //R2
      shortEv && st_r == PSSC_ON && !longEv |=> st_r == PSSC_S1)
      else $error("short press did not sleep");
   AST_WAKE: assert property (@(posedge clk) disable iff (srst) //R4
      shortEv && (st_r == PSSC_S1 || st_r == PSSC_S3) |=> st_r == PSSC_ON)
      else $error("short press did not wake");
   AST_SLP_OFF: assert property (@(posedge clk) disable iff (srst) //R5
      longEv && (st_r == PSSC_S1 || st_r == PSSC_S3 || st_r == PSSC_S4)
      |=> st_r == PSSC_OFF)
      else $error("long hold in sleep did not power off");
   AST_S2_REJ: assert property (@(posedge clk) disable iff (srst) //R6
      st_r == PSSC_ON && reqValid && reqState == REQ_S2 && !shortEv && !longEv
      |=> reqReject && st_r == PSSC_ON)
      else $error("s2 request not rejected");
   AST_S1_PWR: assert property (@(posedge clk) disable iff (srst) //R8
      st_r == PSSC_S1 |-> pwr.cpuStopGrant && pwr.platPwr)
      else $error("s1 power wrong");
   AST_S3_PWR: assert property (@(posedge clk) disable iff (srst) //R9
      st_r == PSSC_S3 |-> pwr.memPwr && !pwr.cpuPwr && pwr.wakePwr)
      else $error("s3 power wrong");
   AST_S4_PWR: assert property (@(posedge clk) disable iff (srst) //R10
      st_r == PSSC_S4 |-> !pwr.cpuPwr && !pwr.memPwr && pwr.wakePwr)
      else $error("s4 power wrong");
   AST_COLD: assert property (@(posedge clk) disable iff (srst) //R11
      $past(st_r) == PSSC_OFF && st_r != PSSC_OFF |-> pwr.coldReset)
      else $error("left soft-off without cold boot");
   AST_USB: assert property (@(posedge clk) disable iff (srst) //R13
      st_r == PSSC_S4 && !shortEv && !longEv && !pmeS && !rtcS && !lanS
      && !reqValid |=> st_r == PSSC_S4)
      else $error("usb woke from s4");
   AST_ONCE: assert property (@(posedge clk) disable iff (srst) //R17
      longEv |=> !longEv [*2])
      else $error("long hold acted twice");
   AST_S5_RST: assert property (@(posedge clk) //R15
      srst |=> !s5En_r)
      else $error("s5 wake enabled after reset");
   COV_LONG: cover property (@(posedge clk) disable iff (srst)
      st_r == PSSC_ON && longEv);
   COV_S3: cover property (@(posedge clk) disable iff (srst)
      st_r == PSSC_S3 ##1 st_r == PSSC_ON);
   COV_REJ: cover property (@(posedge clk) disable iff (srst) reqReject);
endmodule // pssc_top
`default_nettype wire

// ### test/pssc_panel_model.sv
// pssc_panel_model: front panel power switch seen from the board side
// assumes the bench calls down/up; inputs move on the falling edge
`timescale 1ns/1ps
`default_nettype none
module pssc_panel_model (
   input wire logic clk, // standby clock
   output var logic pwrBtnN // switch contact, low while pressed
);
   // released contact sits on its pull-up, never left floating
   initial pwrBtnN = 1'b1;

   task automatic down();
      @(negedge clk) pwrBtnN = 1'b0;
   endtask

   task automatic up();
      @(negedge clk) pwrBtnN = 1'b1;
   endtask
endmodule // pssc_panel_model
`default_nettype wire

// ### test/tb_top.sv
// tb_top: scenario bench for the power switch and sleep state controller
// assumes short counts on the dut so a long hold takes a few hundred cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import pssc_pkg::*;
   localparam int HOLD = 200;
   localparam int DEB = 4;
   localparam int BOOT = 8;
   logic clk, srst, pmeN, usbWake, lanWake, acWasOn, reqValid, cfgS5Write;
   logic [2:0] reqState;
   wire logic pwrBtnN;
   pssc_cfg_s cfg;
   pssc_pwr_s pwr;
   logic [2:0] curState;
   logic reqReject, rejSeen;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;

   pssc_panel_model u_panel (.clk(clk), .pwrBtnN(pwrBtnN));
   pssc_top #(.HOLD_CYCLES(HOLD), .DEB_CYCLES(DEB), .BOOT_CYCLES(BOOT))
   u_dut (.clk(clk), .srst(srst), .pwrBtnN(pwrBtnN), .pmeN(pmeN),
      .usbWake(usbWake), .rtcAlarm(1'b0), .lanWake(lanWake),
      .acWasOn(acWasOn), .reqValid(reqValid), .reqState(reqState),
      .cfg(cfg), .cfgS5Write(cfgS5Write), .pwr(pwr),
      .curState(curState), .reqReject(reqReject));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // mid-cycle sampling sees the registered reject pulse settled
   always @(negedge clk) begin
      cyc++;
      if (reqReject === 1'b1) rejSeen = 1'b1;
      if (cyc == 20000) begin
         fail_count++;
         conclude();
      end
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // bounded wait for a state code, then judge it
   task automatic waitSt(input logic [2:0] exp, input int lim);
      for (int i = 0; i < lim && curState !== exp; i++) @(negedge clk);
      chk(curState, exp);
   endtask

   task automatic doReset();
      @(negedge clk) srst = 1'b1;
      repeat (2) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic press(input int n);
      u_panel.down();
      repeat (n) @(negedge clk);
      u_panel.up();
   endtask

   task automatic request(input logic [2:0] s);
      rejSeen = 1'b0;
      @(negedge clk) reqValid = 1'b1;
      reqState = s;
      @(negedge clk) reqValid = 1'b0;
      repeat (3) @(negedge clk);
   endtask

   task automatic scResetOff();
      doReset();
      chk(curState, 3'h5);
      chk(pwr.wakePwr, 1'b1);
      chk(pwr.cpuPwr, 1'b0);
   endtask

   task automatic scPmeFromOff();
      @(negedge clk) pmeN = 1'b0;
      lanWake = 1'b1;
      repeat (10) @(negedge clk);
      chk(curState, 3'h5);
      pmeN = 1'b1;
      lanWake = 1'b0;
      @(negedge clk) cfgS5Write = 1'b1;
      @(negedge clk) cfgS5Write = 1'b0;
      pmeN = 1'b0;
      waitSt(3'h0, 20);
      pmeN = 1'b1;
      chk(pwr.coldReset, 1'b1);
      repeat (BOOT + 4) @(negedge clk);
      chk(pwr.coldReset, 1'b0);
      chk(pwr.cpuPwr, 1'b1);
   endtask

   task automatic scPressSleepWake();
      press(20);
      waitSt(3'h1, 20);
      chk(pwr.cpuStopGrant, 1'b1);
      chk(pwr.platPwr, 1'b1);
      press(20);
      waitSt(3'h0, 20);
      repeat (BOOT + 4) @(negedge clk);
   endtask

   task automatic scRequests();
      request(REQ_S2);
      chk(rejSeen, 1'b1);
      chk(curState, 3'h0);
      request(REQ_S3);
      chk(rejSeen, 1'b0);
      chk(curState, 3'h3);
      chk({pwr.cpuPwr, pwr.memPwr, pwr.wakePwr}, 3'h3);
      @(negedge clk) usbWake = 1'b1;
      waitSt(3'h0, 20);
      usbWake = 1'b0;
      repeat (BOOT + 4) @(negedge clk);
      request(REQ_S4);
      chk(curState, 3'h4);
      chk({pwr.cpuPwr, pwr.memPwr, pwr.wakePwr}, 3'h1);
      @(negedge clk) usbWake = 1'b1;
      repeat (10) @(negedge clk);
      chk(curState, 3'h4);
      usbWake = 1'b0;
      pmeN = 1'b0;
      waitSt(3'h0, 20);
      pmeN = 1'b1;
      repeat (4) @(negedge clk);
      chk(pwr.coldReset, 1'b1);
      repeat (BOOT + 4) @(negedge clk);
   endtask

   task automatic scLongHold();
      u_panel.down();
      repeat (HOLD + 30) @(negedge clk);
      chk(curState, 3'h5);
      u_panel.up();
      repeat (20) @(negedge clk);
      chk(curState, 3'h5);
      press(20);
      waitSt(3'h0, 20);
      repeat (BOOT + 4) @(negedge clk);
      request(REQ_S1);
      chk(curState, 3'h1);
      press(HOLD + 30);
      waitSt(3'h5, 20);
   endtask

   task automatic scRestore();
      acWasOn = 1'b1;
      doReset();
      waitSt(3'h0, 10);
      chk(pwr.coldReset, 1'b1);
   endtask

   initial begin
      srst = 1'b1;
      pmeN = 1'b1;
      usbWake = 1'b0;
      lanWake = 1'b0;
      acWasOn = 1'b0;
      reqValid = 1'b0;
      reqState = 3'h0;
      cfgS5Write = 1'b0;
      cfg = 6'h3b; // every wake enable but rtc, restore on
      rejSeen = 1'b0;
      scResetOff();
      scPmeFromOff();
      scPressSleepWake();
      scRequests();
      scLongHold();
      scRestore();
      conclude();
   end
endmodule // tb_top
`default_nettype wire
